// *** inc/uin_pkg.sv ***
// constants, encodings and register map of the universal input readout
package uin_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int CLK_NS = 8;
  // sampling period of 1.1(1) ms, kept as nine times its length in ns
  localparam int TICK_NS_X9 = 10000000;
  localparam int TICK_CYC = (TICK_NS_X9 + (9 * CLK_NS) / 2) / (9 * CLK_NS);
  localparam int DEB_MS = 100;
  localparam int DEB_CYC = DEB_MS * 1000000 / CLK_NS;
  localparam int DIV_W = 40;
  localparam logic [DIV_W-1:0] FREQ_NUM = 40'(64'(CLK_HZ) * 64'h3E8);
  // frequency thresholds in mHz, low range then high range
  localparam logic [31:0] FLOOR_LO = 32'h000023C3;
  localparam logic [31:0] FLOOR_HI = 32'h0001659E;
  localparam logic [31:0] ZERO_LO = 32'h0000251C;
  localparam logic [31:0] ZERO_HI = 32'h00017318;
  localparam logic [31:0] OVER_LO = 32'h00124F80;
  localparam logic [31:0] OVER_HI = 32'h00B71B00;
  localparam int LOSS_CYC_LO = int'((64'(FREQ_NUM) + 64'(FLOOR_LO) - 1) / 64'(FLOOR_LO));
  localparam int LOSS_CYC_HI = int'((64'(FREQ_NUM) + 64'(FLOOR_HI) - 1) / 64'(FLOOR_HI));
  // resistance thresholds in ohm
  localparam logic [31:0] RES_ZERO = 32'h00000014;
  localparam logic [31:0] RES_R1 = 32'h00000064;
  localparam logic [31:0] RES_R2 = 32'h0000044C;
  localparam logic [31:0] RES_R3 = 32'h00002B5C;
  localparam logic [6:0] WIN_50 = 7'h12;
  localparam logic [6:0] WIN_60 = 7'h0F;
  localparam logic [6:0] WIN_BOTH = 7'h5A;
  localparam int WIN_DEPTH = 90;
  localparam logic [15:0] SWK_RST = 16'h000A;
  localparam logic [15:0] SWK_MAX = 16'hEA60;
  localparam logic [31:0] DUTY_FULL = 32'h00002710;
  localparam logic [16:0] NORM_ONE = 17'h10000;
  localparam logic [16:0] NORM_HALF = 17'h08000;
  localparam int NORM_SHIFT = 16;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SWK = 8'h04;
  localparam logic [7:0] REG_LIM0 = 8'h08;
  localparam logic [7:0] REG_MEAS = 8'h30;
  localparam logic [7:0] REG_OUT = 8'h34;
  localparam int NUM_LIM = 10;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_FHI = 3;
  localparam int CTRL_AF = 4;
  localparam int CTRL_POL = 6;
  localparam int CTRL_SWT = 7;
  localparam logic [31:0] CTRL_RST = 32'h00000031;
  // limits: Vmin Vmax (mV) Imin Imax (uA) Rmin Rmax (ohm) Fmin Fmax (mHz) Dmin Dmax (0.01 %)
  localparam logic [NUM_LIM-1:0][31:0] LIM_RST = {32'h00002710, 32'h00000000,
    32'h000F4240, 32'h00000028, 32'h0003D090, 32'h0000001E, 32'h00004E20, 32'h00000000,
    32'h00001388, 32'h00000000};
  typedef enum logic [2:0] {MODE_OFF, MODE_VOLT, MODE_CURR, MODE_RES, MODE_DISC, MODE_FREQ,
    MODE_DUTY} mode_t;
  typedef enum logic [1:0] {AF_OFF, AF_50, AF_60, AF_BOTH} afilt_t;
  typedef enum logic [1:0] {SWF_NONE, SWF_MOVING, SWF_REPEAT} swf_t;
  typedef enum logic [1:0] {SIG_NA, SIG_VALID, SIG_ERROR} sig_state_t;
endpackage

// *** inc/div_if.sv ***
// request and answer lines of the shared sequential divider
`timescale 1ns/10ps
interface div_if;
  logic start;
  logic [uin_pkg::DIV_W-1:0] num;
  logic [uin_pkg::DIV_W-1:0] den;
  logic [uin_pkg::DIV_W-1:0] quo;
  logic busy;
  logic done;
  modport master(output start, output num, output den, input quo, input busy, input done);
  modport slave(input start, input num, input den, output quo, output busy, output done);
endinterface

// *** src/seq_divider.sv ***
// restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module seq_divider import uin_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  div_if.slave div
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [DIV_W-1:0] rem;
    logic [DIV_W-1:0] quo;
    logic [DIV_W-1:0] den;
  } div_st_t;
  div_st_t s_q, s_d;

  always_comb begin
    logic [DIV_W:0] trial;
    trial = '0;
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && div.start) begin
      s_d.busy = 1'b1;
      s_d.cnt = 6'(DIV_W);
      s_d.quo = div.num;
      s_d.rem = '0;
      s_d.den = div.den;
    end else if (s_q.busy) begin
      trial = {s_q.rem, s_q.quo[DIV_W-1]} - {1'b0, s_q.den};
      if (!trial[DIV_W]) begin
        s_d.rem = trial[DIV_W-1:0];
        s_d.quo = {s_q.quo[DIV_W-2:0], 1'b1};
      end else begin
        s_d.rem = {s_q.rem[DIV_W-2:0], s_q.quo[DIV_W-1]};
        s_d.quo = {s_q.quo[DIV_W-2:0], 1'b0};
      end
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign div.quo = s_q.quo;
  assign div.busy = s_q.busy;
  assign div.done = s_q.done;
endmodule

// *** src/window_avg.sv ***
// running sum over the last win samples, window up to WIN_DEPTH
`timescale 1ns/10ps
module window_avg import uin_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic push,
  input wire logic [31:0] sample,
  input wire logic [6:0] win,
  output logic [38:0] sum,
  output logic [6:0] fill
);
  typedef struct packed {
    logic [6:0] wr;
    logic [6:0] fill;
    logic [38:0] sum;
  } win_st_t;
  win_st_t s_q, s_d;
  logic [31:0] mem [WIN_DEPTH];
  logic [6:0] oldIdx;

  always_comb begin
    s_d = s_q;
    oldIdx = (s_q.wr >= win) ? s_q.wr - win : 7'(s_q.wr + 7'(WIN_DEPTH) - win);
    if (clear) begin
      s_d = '0;
    end else if (push) begin
      s_d.sum = s_q.sum + 39'(sample);
      if (s_q.fill == win) begin
        s_d.sum = s_q.sum + 39'(sample) - 39'(mem[oldIdx]);
      end else begin
        s_d.fill = s_q.fill + 7'h01;
      end
      s_d.wr = (s_q.wr == 7'(WIN_DEPTH - 1)) ? 7'h00 : s_q.wr + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !clear) begin
      mem[s_q.wr] <= sample;
    end
  end

  assign sum = s_q.sum;
  assign fill = s_q.fill;
endmodule

// *** src/universal_input_readout.sv ***
// universal input channel: sampling, filtering and normalisation
`timescale 1ns/10ps
module universal_input_readout import uin_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int LOSS_LO_CYCLES = LOSS_CYC_LO,
  parameter int LOSS_HI_CYCLES = LOSS_CYC_HI
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [31:0] analogSample,
  input wire logic sigIn,
  output logic [16:0] normOut,
  output sig_state_t sigState,
  output logic errCode,
  output logic discreteOut,
  output logic outStrobe,
  output logic [1:0] resRange
);
  typedef enum logic [3:0] {SQ_IDLE, SQ_AVG, SQ_FREQ, SQ_DUTY, SQ_SWF, SQ_MOV, SQ_REP,
    SQ_NORM, SQ_NWAIT} seq_t;

  typedef struct packed {
    mode_t mode;
    logic fhi;
    afilt_t af;
    logic pol;
    swf_t swt;
    logic [15:0] swk;
    logic [NUM_LIM-1:0][31:0] lim;
    logic [31:0] rdata;
    logic [17:0] tickCnt;
    logic tick;
    logic lvlPrev;
    logic [31:0] perCnt;
    logic [31:0] hiCnt;
    logic [31:0] period;
    logic [31:0] high;
    logic lost;
    logic [23:0] debCnt;
    logic debLevel;
    seq_t seq;
    logic divGo;
    logic [DIV_W-1:0] divNum;
    logic [DIV_W-1:0] divDen;
    logic [31:0] meas;
    logic [31:0] filt;
    logic negStep;
    logic [47:0] repSum;
    logic [15:0] repCnt;
    logic [16:0] normOut;
    sig_state_t sigState;
    logic errCode;
    logic discrete;
    logic outStrobe;
    logic [1:0] resRange;
    logic avgClear;
    logic avgPush;
  } st_t;
  st_t s_q, s_d;

  div_if div();
  logic [38:0] winSum;
  logic [6:0] winFill;
  logic [6:0] winLen;
  logic winPush;

  seq_divider u_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .div(div.slave)
  );

  window_avg u_win (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clear(s_q.avgClear),
    .push(winPush),
    .sample(s_q.meas),
    .win(winLen),
    .sum(winSum),
    .fill(winFill)
  );

  assign div.start = s_q.divGo;
  assign div.num = s_q.divNum;
  assign div.den = s_q.divDen;

  always_comb begin
    case (s_q.af)
      AF_50: winLen = WIN_50;
      AF_60: winLen = WIN_60;
      AF_BOTH: winLen = WIN_BOTH;
      default: winLen = 7'h01;
    endcase
  end

  // the window takes the sample latched in the tick cycle, at most once per tick
  assign winPush = s_q.avgPush;

  always_comb begin
    logic lvl;
    logic [31:0] lossCyc;
    logic [31:0] fq;
    logic [31:0] sample;
    logic [31:0] mn;
    logic [31:0] mx;
    logic [3:0] li;
    logic [31:0] diff;
    logic [47:0] repNext;
    lvl = sigIn ^ s_q.pol;
    lossCyc = s_q.fhi ? 32'(LOSS_HI_CYCLES) : 32'(LOSS_LO_CYCLES);
    fq = div.quo[31:0];
    sample = analogSample;
    mn = '0;
    mx = '0;
    li = 4'h0;
    diff = '0;
    repNext = s_q.repSum + 48'(s_q.meas);
    s_d = s_q;
    s_d.divGo = 1'b0;
    s_d.outStrobe = 1'b0;
    s_d.avgClear = 1'b0;
    s_d.avgPush = 1'b0;
    s_d.rdata = '0;

    // register port
    if (regWr) begin
      case (regAddr)
        REG_CTRL: begin
          s_d.mode = mode_t'(regWdata[CTRL_MODE +: 3]);
          s_d.fhi = regWdata[CTRL_FHI];
          s_d.af = afilt_t'(regWdata[CTRL_AF +: 2]);
          s_d.pol = regWdata[CTRL_POL];
          s_d.swt = swf_t'(regWdata[CTRL_SWT +: 2]);
          s_d.avgClear = 1'b1;
          s_d.filt = '0;
          s_d.repSum = '0;
          s_d.repCnt = '0;
        end
        REG_SWK: begin
          s_d.swk = (regWdata > 32'(SWK_MAX)) ? SWK_MAX : regWdata[15:0];
        end
        default: begin
          for (int i = 0; i < NUM_LIM; i++) begin
            if (regAddr == 8'(REG_LIM0 + 8'(4 * i))) begin
              s_d.lim[i] = regWdata;
            end
          end
        end
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL: s_d.rdata = 32'({s_q.swt, s_q.pol, s_q.af, s_q.fhi, s_q.mode});
        REG_SWK: s_d.rdata = 32'(s_q.swk);
        REG_MEAS: s_d.rdata = s_q.meas;
        REG_OUT: s_d.rdata = 32'({s_q.errCode, s_q.sigState, s_q.normOut});
        default: begin
          for (int i = 0; i < NUM_LIM; i++) begin
            if (regAddr == 8'(REG_LIM0 + 8'(4 * i))) begin
              s_d.rdata = s_q.lim[i];
            end
          end
        end
      endcase
    end

    // sampling tick
    s_d.tick = 1'b0;
    if (s_q.tickCnt == 18'(TICK_CYCLES - 1)) begin
      s_d.tickCnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tickCnt = s_q.tickCnt + 18'h00001;
    end

    // period and high time between active edges
    s_d.lvlPrev = lvl;
    if (lvl && !s_q.lvlPrev) begin
      s_d.period = s_q.perCnt + 32'h00000001;
      s_d.high = s_q.hiCnt;
      s_d.perCnt = '0;
      s_d.hiCnt = '0;
      s_d.lost = 1'b0;
    end else if (s_q.perCnt >= lossCyc) begin
      s_d.lost = 1'b1;
    end else begin
      s_d.perCnt = s_q.perCnt + 32'h00000001;
      s_d.hiCnt = s_q.hiCnt + 32'(lvl);
    end

    // discrete debounce
    if (lvl == s_q.debLevel) begin
      s_d.debCnt = '0;
    end else if (s_q.debCnt == 24'(DEB_CYCLES - 1)) begin
      s_d.debLevel = lvl;
      s_d.debCnt = '0;
    end else begin
      s_d.debCnt = s_q.debCnt + 24'h000001;
    end

    case (s_q.mode)
      MODE_VOLT: li = 4'h0;
      MODE_CURR: li = 4'h2;
      MODE_RES: li = 4'h4;
      MODE_FREQ: li = 4'h6;
      default: li = 4'h8;
    endcase
    mn = s_q.lim[li];
    mx = s_q.lim[li + 4'h1];

    case (s_q.seq)
      SQ_IDLE: begin
        if (s_q.tick) begin
          case (s_q.mode)
            MODE_OFF: begin
              s_d.normOut = '0;
              s_d.sigState = SIG_NA;
              s_d.errCode = 1'b0;
              s_d.discrete = 1'b0;
              s_d.outStrobe = 1'b1;
            end
            MODE_DISC: begin
              s_d.meas = 32'(s_q.debLevel);
              s_d.normOut = s_q.debLevel ? NORM_ONE : '0;
              s_d.discrete = s_q.debLevel;
              s_d.sigState = SIG_VALID;
              s_d.errCode = 1'b0;
              s_d.outStrobe = 1'b1;
            end
            MODE_VOLT, MODE_CURR, MODE_RES: begin
              if (s_q.mode == MODE_RES && sample < RES_ZERO) begin
                sample = '0;
              end
              s_d.meas = sample;
              s_d.avgPush = (s_q.af != AF_OFF);
              s_d.seq = (s_q.af == AF_OFF) ? SQ_SWF : SQ_AVG;
            end
            default: begin
              if (s_q.lost && s_q.mode == MODE_DUTY) begin
                s_d.meas = lvl ? DUTY_FULL : '0;
                s_d.seq = SQ_SWF;
              end else if (s_q.lost) begin
                s_d.normOut = '0;
                s_d.sigState = SIG_ERROR;
                s_d.errCode = 1'b0;
                s_d.discrete = 1'b0;
                s_d.outStrobe = 1'b1;
              end else begin
                s_d.divGo = 1'b1;
                s_d.divNum = FREQ_NUM;
                s_d.divDen = DIV_W'(s_q.period);
                s_d.seq = SQ_FREQ;
              end
            end
          endcase
        end
      end
      SQ_AVG: begin
        // one cycle after the push the window sum is current
        if (!winPush && !s_q.divGo && !div.busy && !div.done && winFill != 7'h00) begin
          s_d.divGo = 1'b1;
          s_d.divNum = DIV_W'(winSum);
          s_d.divDen = DIV_W'(winFill);
        end
        if (div.done) begin
          s_d.meas = div.quo[31:0];
          s_d.seq = SQ_SWF;
        end
      end
      SQ_FREQ: begin
        if (div.done) begin
          if (fq >= (s_q.fhi ? OVER_HI : OVER_LO) || div.quo[DIV_W-1:32] != '0) begin
            s_d.errCode = 1'b1;
            s_d.sigState = SIG_ERROR;
            s_d.normOut = '0;
            s_d.discrete = 1'b0;
            s_d.outStrobe = 1'b1;
            s_d.seq = SQ_IDLE;
          end else if (fq < (s_q.fhi ? FLOOR_HI : FLOOR_LO) && s_q.mode == MODE_FREQ) begin
            s_d.errCode = 1'b0;
            s_d.sigState = SIG_ERROR;
            s_d.normOut = '0;
            s_d.discrete = 1'b0;
            s_d.outStrobe = 1'b1;
            s_d.seq = SQ_IDLE;
          end else if (s_q.mode == MODE_FREQ) begin
            s_d.meas = (fq < (s_q.fhi ? ZERO_HI : ZERO_LO)) ? '0 : fq;
            s_d.seq = SQ_SWF;
          end else begin
            s_d.divGo = 1'b1;
            s_d.divNum = DIV_W'(64'(s_q.high) * 64'(DUTY_FULL));
            s_d.divDen = DIV_W'(s_q.period);
            s_d.seq = SQ_DUTY;
          end
        end
      end
      SQ_DUTY: begin
        if (div.done) begin
          s_d.meas = div.quo[31:0];
          s_d.seq = SQ_SWF;
        end
      end
      SQ_SWF: begin
        if (s_q.mode == MODE_RES) begin
          if (s_q.meas < RES_R1) begin
            s_d.resRange = 2'h0;
          end else if (s_q.meas <= RES_R2) begin
            s_d.resRange = 2'h1;
          end else if (s_q.meas <= RES_R3) begin
            s_d.resRange = 2'h2;
          end else begin
            s_d.resRange = 2'h3;
          end
        end
        if (s_q.swt == SWF_MOVING && s_q.swk != '0) begin
          s_d.negStep = s_q.meas < s_q.filt;
          diff = (s_q.meas < s_q.filt) ? s_q.filt - s_q.meas : s_q.meas - s_q.filt;
          s_d.divGo = 1'b1;
          s_d.divNum = DIV_W'(diff);
          s_d.divDen = DIV_W'(s_q.swk);
          s_d.seq = SQ_MOV;
        end else if (s_q.swt == SWF_REPEAT && s_q.swk != '0) begin
          if (s_q.repCnt + 16'h0001 >= s_q.swk) begin
            s_d.divGo = 1'b1;
            s_d.divNum = DIV_W'(repNext);
            s_d.divDen = DIV_W'(s_q.swk);
            s_d.repSum = '0;
            s_d.repCnt = '0;
            s_d.seq = SQ_REP;
          end else begin
            s_d.repSum = repNext;
            s_d.repCnt = s_q.repCnt + 16'h0001;
            s_d.seq = SQ_NORM;
          end
        end else begin
          s_d.filt = s_q.meas;
          s_d.seq = SQ_NORM;
        end
      end
      SQ_MOV: begin
        if (div.done) begin
          s_d.filt = s_q.negStep ? s_q.filt - div.quo[31:0] : s_q.filt + div.quo[31:0];
          s_d.seq = SQ_NORM;
        end
      end
      SQ_REP: begin
        if (div.done) begin
          s_d.filt = div.quo[31:0];
          s_d.seq = SQ_NORM;
        end
      end
      SQ_NORM: begin
        s_d.sigState = SIG_VALID;
        s_d.errCode = 1'b0;
        if (s_q.filt <= mn) begin
          s_d.normOut = '0;
          s_d.discrete = 1'b0;
          s_d.outStrobe = 1'b1;
          s_d.seq = SQ_IDLE;
        end else if (s_q.filt >= mx) begin
          s_d.normOut = NORM_ONE;
          s_d.discrete = 1'b1;
          s_d.outStrobe = 1'b1;
          s_d.seq = SQ_IDLE;
        end else begin
          s_d.divGo = 1'b1;
          s_d.divNum = DIV_W'(s_q.filt - mn) << NORM_SHIFT;
          s_d.divDen = DIV_W'(mx - mn);
          s_d.seq = SQ_NWAIT;
        end
      end
      SQ_NWAIT: begin
        if (div.done) begin
          s_d.normOut = div.quo[16:0];
          s_d.discrete = div.quo[16:0] >= NORM_HALF;
          s_d.outStrobe = 1'b1;
          s_d.seq = SQ_IDLE;
        end
      end
      default: s_d.seq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.mode <= mode_t'(CTRL_RST[CTRL_MODE +: 3]);
      s_q.af <= afilt_t'(CTRL_RST[CTRL_AF +: 2]);
      s_q.swt <= swf_t'(CTRL_RST[CTRL_SWT +: 2]);
      s_q.swk <= SWK_RST;
      s_q.lim <= LIM_RST;
      s_q.seq <= SQ_IDLE;
      s_q.sigState <= SIG_NA;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign normOut = s_q.normOut;
  assign sigState = s_q.sigState;
  assign errCode = s_q.errCode;
  assign discreteOut = s_q.discrete;
  assign outStrobe = s_q.outStrobe;
  assign resRange = s_q.resRange;
endmodule

// *** tb/universal_input_readout_chk.sv ***
// port checker for the universal input readout
`timescale 1ns/10ps
module universal_input_readout_chk import uin_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [16:0] normOut,
  input wire sig_state_t sigState,
  input wire logic errCode,
  input wire logic discreteOut,
  input wire logic outStrobe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not zero without read");
  a_out_read: assert property (regRd && regAddr == REG_OUT |=>
    regRdata == 32'({$past(errCode), $past(sigState), $past(normOut)}))
    else $error("output register read mismatch");
  a_norm_range: assert property (normOut <= NORM_ONE)
    else $error("normalised output above one");
  a_state_zero: assert property (sigState != SIG_VALID |-> normOut == 17'h0)
    else $error("value not zero outside valid state");
  a_disc_half: assert property (discreteOut == (normOut >= NORM_HALF))
    else $error("discrete level disagrees with value");
  a_change_strobe: assert property (!$stable(normOut) || !$stable(sigState) |-> outStrobe)
    else $error("output changed without update strobe");
  a_strobe_pulse: assert property (outStrobe |=> !outStrobe [*8])
    else $error("update strobes too close");
  a_state_legal: assert property (sigState != 2'h3)
    else $error("illegal signal state");
  c_err_high: cover property (outStrobe && sigState == SIG_ERROR && errCode);
  c_err_low: cover property (outStrobe && sigState == SIG_ERROR && !errCode);
  c_full: cover property (outStrobe && normOut == NORM_ONE);
  c_disc_rise: cover property ($rose(discreteOut));
endmodule

// *** tb/pin_source.sv ***
// input pin source: pulse train or steady level
`timescale 1ns/10ps
module pin_source (
  input wire logic ref_clk,
  output logic sigOut = 1'b0
);
  logic run = 1'b0;
  logic level = 1'b0;
  int period = 40;
  int high = 10;
  int cnt = 0;
  // a stopped source holds a steady level, which is a lost carrier
  always @(posedge ref_clk) begin
    if (run) begin
      cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
      sigOut <= cnt < high;
    end else begin
      cnt <= 0;
      sigOut <= level;
    end
  end
endmodule

// *** tb/universal_input_readout_bench.sv ***
// self-checking bench for the universal input readout
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module universal_input_readout_bench import uin_pkg::*;;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] analogSample = 32'h0;
  logic [31:0] regRdata;
  logic [16:0] normOut;
  sig_state_t sigState;
  logic errCode, discreteOut, outStrobe, sigIn, rdPend;
  logic [1:0] resRange;
  logic [20:0] outQ[$];
  logic [31:0] rdQ[$];
  int errorCnt = 0;
  int checked = 0;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rdPend <= regRd;
  universal_input_readout #(.TICK_CYCLES(200), .DEB_CYCLES(16), .LOSS_LO_CYCLES(400),
    .LOSS_HI_CYCLES(100)) uut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .analogSample(analogSample), .sigIn(sigIn), .normOut(normOut), .sigState(sigState),
    .errCode(errCode), .discreteOut(discreteOut), .outStrobe(outStrobe), .resRange(resRange));
  pin_source src (.ref_clk(ref_clk), .sigOut(sigIn));
  // results are taken off the queues where they are settled
  always @(negedge ref_clk) begin
    logic [20:0] e;
    logic [31:0] d;
    if (outStrobe === 1'b1 && outQ.size() > 0) begin
      e = outQ.pop_front();
      `CHK({discreteOut, errCode, sigState, normOut}, e)
    end
    if (rdPend === 1'b1 && rdQ.size() > 0) begin
      d = rdQ.pop_front();
      `CHK(regRdata, d)
    end
  end
  function automatic logic [20:0] ok(input logic [16:0] n);
    return {n >= NORM_HALF, 1'b0, SIG_VALID, n};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask
  task automatic waitStb();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (outStrobe !== 1'b1 && n < 1000);
    `CHK(n < 1000, 1'b1)
  endtask
  // called just after a strobe, so the next tick takes the new sample
  task automatic upd(input logic [31:0] a, input logic [20:0] e);
    analogSample <= a;
    outQ.push_back(e);
    waitStb();
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #720000;
    errorCnt++;
    $display("watchdog expired");
    finishTest();
  end
  initial begin
    int r;
    int w;
    logic [31:0] v;
    int rv[4];
    r = $urandom(15764);
    rv = '{50, 500, 5000, 20000};
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(REG_CTRL, 32'h31);
    rd(REG_SWK, 32'hA);
    rd(REG_LIM0 + 8'h04, 32'h1388);
    rd(REG_LIM0 + 8'h14, 32'h3D090);
    rd(REG_LIM0 + 8'h1C, 32'hF4240);
    wr(REG_SWK, 32'hFFFF);
    rd(REG_SWK, 32'hEA60);
    wr(8'hFC, 32'h1);
    rd(8'hFC, 32'h0);
    $display("registers done");
    wr(REG_LIM0 + 8'h04, 32'h2000);
    wr(REG_CTRL, 32'h1);
    waitStb();
    for (int i = 0; i < 8; i++) begin
      v = $urandom_range(8191);
      upd(v, ok(17'(v * 8)));
    end
    upd(32'h2328, ok(NORM_ONE));
    $display("voltage done");
    for (int k = 1; k < 4; k++) begin
      w = (k == 1) ? 18 : (k == 2) ? 15 : 90;
      wr(REG_CTRL, 32'h1 | (32'(k) << 4));
      analogSample <= 32'h1000;
      repeat (w) waitStb();
      upd(32'h1000, ok(17'h8000));
      analogSample <= 32'h0;
      repeat (w - 1) waitStb();
      `CHK(normOut != 17'h0, 1'b1)
      upd(32'h0, ok(17'h0));
    end
    $display("window done");
    wr(REG_SWK, 32'h2);
    wr(REG_CTRL, 32'h81);
    upd(32'h1F40, ok(17'h7D00));
    upd(32'h1F40, ok(17'hBB80));
    upd(32'h1F40, ok(17'hDAC0));
    wr(REG_SWK, 32'h0);
    upd(32'h4D2, ok(17'h2690));
    wr(REG_SWK, 32'h3);
    wr(REG_CTRL, 32'h101);
    for (int b = 0; b < 2; b++) begin
      upd(b ? 32'hBB8 : 32'h3E8, ok(b ? 17'h3E80 : 17'h0));
      upd(b ? 32'hBB8 : 32'h7D0, ok(b ? 17'h3E80 : 17'h0));
      upd(32'hBB8, ok(b ? 17'h5DC0 : 17'h3E80));
    end
    $display("software filter done");
    wr(REG_LIM0 + 8'h10, 32'h0);
    wr(REG_LIM0 + 8'h14, 32'h2000);
    wr(REG_CTRL, 32'h3);
    upd(32'h13, ok(17'h0));
    upd(32'h14, ok(17'hA0));
    for (int i = 0; i < 4; i++) begin
      upd(rv[i], ok(rv[i] >= 8192 ? NORM_ONE : 17'(rv[i] * 8)));
      `CHK(resRange, 2'(i))
    end
    $display("resistance done");
    src.level <= 1'b1;
    wr(REG_CTRL, 32'h84);
    waitStb();
    upd(32'h0, ok(NORM_ONE));
    src.level <= 1'b0;
    repeat (10) @(posedge ref_clk);
    src.level <= 1'b1;
    upd(32'h0, ok(NORM_ONE));
    wr(REG_CTRL, 32'hC4);
    waitStb();
    upd(32'h0, ok(17'h0));
    $display("discrete done");
    for (int h = 0; h < 2; h++) begin
      src.run <= 1'b1;
      wr(REG_CTRL, 32'h5 | (32'(h) << 3));
      waitStb();
      upd(32'h0, {1'b0, 1'b1, SIG_ERROR, 17'h0});
      src.run <= 1'b0;
      repeat (3) waitStb();
      upd(32'h0, {1'b0, 1'b0, SIG_ERROR, 17'h0});
    end
    $display("frequency done");
    wr(REG_LIM0 + 8'h1C, 32'h7D0);
    for (int c = 0; c < 4; c++) begin
      src.level <= c[0];
      wr(REG_CTRL, 32'h6 | (32'(c[1]) << 6));
      repeat (3) waitStb();
      upd(32'h0, ok((c[0] ^ c[1]) ? NORM_ONE : 17'h0));
    end
    $display("duty done");
    wr(REG_CTRL, 32'h0);
    waitStb();
    upd(32'h0, {1'b0, 1'b0, SIG_NA, 17'h0});
    rd(REG_OUT, 32'h0);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK({outStrobe, errCode, sigState, normOut}, 21'h0)
    resetn <= 1'b1;
    rd(REG_CTRL, 32'h31);
    repeat (2) @(posedge ref_clk);
    $display("reset done");
    finishTest();
  end
endmodule
bind universal_input_readout universal_input_readout_chk chk (.ref_clk(ref_clk),
  .resetn(resetn), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .normOut(normOut), .sigState(sigState), .errCode(errCode),
  .discreteOut(discreteOut), .outStrobe(outStrobe));
